/* File: src/tcp_pkg.sv */
// types of the timer compare unit
`default_nettype none
package tcp_pkg;
    typedef enum logic [2:0] {
        TCP_NORMAL = 3'b001,
        TCP_ONE_PULSE = 3'b010,
        TCP_PWM = 3'b100
    } tcp_mode_e;
    typedef logic [15:0] tcp_word_t;
endpackage : tcp_pkg
`default_nettype wire

/* File: src/tcp_regs.svh */
// register map, field positions and reset values of the compare unit
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH
`define TCP_ADR_CTRL1 6'h00
`define TCP_ADR_CTRL2 6'h04
`define TCP_ADR_CMP1_HI 6'h08
`define TCP_ADR_CMP1_LO 6'h0C
`define TCP_ADR_CMP2_HI 6'h10
`define TCP_ADR_CMP2_LO 6'h14
`define TCP_ADR_STATUS 6'h18
`define TCP_ADR_COUNT 6'h1C
`define TCP_ADR_CAP1 6'h20
`define TCP_ADR_CAP2 6'h24
`define TCP_B_CAP_IE 7
`define TCP_B_MATCH_IE 6
`define TCP_B_OVF_IE 5
`define TCP_B_FORCE2 4
`define TCP_B_FORCE1 3
`define TCP_B_LVL2 2
`define TCP_B_CAP1_EDGE 1
`define TCP_B_LVL1 0
`define TCP_B_PIN1_EN 7
`define TCP_B_PIN2_EN 6
`define TCP_B_ONE_PULSE 5
`define TCP_B_PWM 4
`define TCP_B_CLK_HI 3
`define TCP_B_CLK_LO 2
`define TCP_B_CAP2_EDGE 1
`define TCP_B_EXT_EDGE 0
`define TCP_F_CAP1 7
`define TCP_F_MATCH1 6
`define TCP_F_OVF 5
`define TCP_F_CAP2 4
`define TCP_F_MATCH2 3
`define TCP_CTRL_RST 8'h00
`define TCP_CMP_HI_RST 8'h80
`define TCP_CMP_LO_RST 8'h00
`define TCP_CNT_RELOAD 16'hFFFC
`define TCP_CNT_TOP 16'hFFFF
`define TCP_CMP_ADJ 16'h0001
`define TCP_CLK_DIV4 2'b00
`define TCP_CLK_DIV2 2'b01
`define TCP_CLK_DIV8 2'b10
`define TCP_CLK_EXT 2'b11
`define TCP_PRE_DIV2 3'b001
`define TCP_PRE_DIV4 3'b011
`define TCP_PRE_DIV8 3'b111
`endif

/* File: src/tcp_unit.sv */
// timer compare, forced compare, one-pulse and modulation unit
`default_nettype none
`include "tcp_regs.svh"
module tcp_unit
    import tcp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic first_capture_input_i,
    input wire logic second_capture_input_i,
    input wire logic ext_timer_clock_pin_i,
    output logic first_compare_pin_o,
    output logic first_compare_pin_oe_n_o,
    output logic second_compare_pin_o,
    output logic second_compare_pin_oe_n_o,
    output logic timer_irq_o
);
    // ********************************************************
    // functions
    // ********************************************************
    function automatic tcp_mode_e mode_of(input logic [7:0] c2);
        if (c2[`TCP_B_PWM]) begin
            return TCP_PWM;
        end else if (c2[`TCP_B_ONE_PULSE]) begin
            return TCP_ONE_PULSE;
        end
        return TCP_NORMAL;
    endfunction : mode_of

    function automatic logic edge_of(input logic now, input logic was,
                                     input logic rise);
        return rise ? (now & ~was) : (~now & was);
    endfunction : edge_of

    // ********************************************************
    // registers and state
    // ********************************************************
    logic [7:0] timer_control_one;
    logic [7:0] timer_control_two;
    logic [7:0] compare_high_byte [2];
    logic [7:0] compare_low_byte [2];
    tcp_word_t active_cmp [2];
    logic inhibit [2];
    logic match [2];
    tcp_word_t count;
    logic count_new;
    logic [2:0] prescale;
    logic [7:0] flags;
    tcp_word_t first_capture_value;
    tcp_word_t second_capture_value;
    logic [2:0] pin_sync [3];
    logic pin_level [3];
    logic pin_prev [3];
    tcp_mode_e mode;
    logic req;
    logic wr;
    logic tick;
    logic ext_edge;
    logic cap1_edge;
    logic cap2_edge;
    logic pwm_end;
    logic opm_start;
    logic [1:0] clk_sel;

    assign mode = mode_of(timer_control_two);
    assign clk_sel = timer_control_two[`TCP_B_CLK_HI:`TCP_B_CLK_LO];
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];

    // ********************************************************
    // wishbone slave
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req & ~wb_ack_o) begin
            unique case (wb_adr_i)
                `TCP_ADR_CTRL1: wb_dat_o <= {24'h00_0000, timer_control_one};
                `TCP_ADR_CTRL2: wb_dat_o <= {24'h00_0000, timer_control_two};
                `TCP_ADR_CMP1_HI:
                    wb_dat_o <= {24'h00_0000, compare_high_byte[0]};
                `TCP_ADR_CMP1_LO:
                    wb_dat_o <= {24'h00_0000, compare_low_byte[0]};
                `TCP_ADR_CMP2_HI:
                    wb_dat_o <= {24'h00_0000, compare_high_byte[1]};
                `TCP_ADR_CMP2_LO:
                    wb_dat_o <= {24'h00_0000, compare_low_byte[1]};
                `TCP_ADR_STATUS: wb_dat_o <= {24'h00_0000, flags};
                `TCP_ADR_COUNT: wb_dat_o <= {16'h0000, count};
                `TCP_ADR_CAP1: wb_dat_o <= {16'h0000, first_capture_value};
                `TCP_ADR_CAP2: wb_dat_o <= {16'h0000, second_capture_value};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_control_one <= `TCP_CTRL_RST;
            timer_control_two <= `TCP_CTRL_RST;
        end else if (wr && wb_adr_i == `TCP_ADR_CTRL1) begin
            timer_control_one <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i == `TCP_ADR_CTRL2) begin
            timer_control_two <= wb_dat_i[7:0];
        end
    end

    // ********************************************************
    // input synchronisers
    // ********************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            logic raw;
            if (gi == 0) begin : g_ext
                assign raw = ext_timer_clock_pin_i;
            end else if (gi == 1) begin : g_c1
                assign raw = first_capture_input_i;
            end else begin : g_c2
                assign raw = second_capture_input_i;
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_sync[gi] <= 3'b000;
                    pin_level[gi] <= 1'b0;
                    pin_prev[gi] <= 1'b0;
                end else begin
                    pin_sync[gi] <= {pin_sync[gi][1:0], raw};
                    if (pin_sync[gi][1] == pin_sync[gi][2]) begin
                        pin_level[gi] <= pin_sync[gi][2];
                    end
                    pin_prev[gi] <= pin_level[gi];
                end
            end
        end
    endgenerate

    assign ext_edge = edge_of(pin_level[0], pin_prev[0],
                              timer_control_two[`TCP_B_EXT_EDGE]);
    assign cap1_edge = edge_of(pin_level[1], pin_prev[1],
                               timer_control_one[`TCP_B_CAP1_EDGE]);
    assign cap2_edge = edge_of(pin_level[2], pin_prev[2],
                               timer_control_two[`TCP_B_CAP2_EDGE]);

    // ********************************************************
    // timer clock and counter
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prescale <= 3'b000;
        end else begin
            prescale <= prescale + 3'b001;
        end
    end

    always_comb begin
        unique case (clk_sel)
            `TCP_CLK_DIV4: tick = (prescale[1:0] == `TCP_PRE_DIV4);
            `TCP_CLK_DIV2: tick = (prescale[0:0] == `TCP_PRE_DIV2);
            `TCP_CLK_DIV8: tick = (prescale == `TCP_PRE_DIV8);
            `TCP_CLK_EXT: tick = ext_edge;
        endcase
    end

    assign pwm_end = (mode == TCP_PWM) & match[1];
    assign opm_start = (mode == TCP_ONE_PULSE) & cap1_edge;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= `TCP_CNT_RELOAD;
            count_new <= 1'b0;
        end else begin
            count_new <= tick | pwm_end | opm_start;
            if (pwm_end | opm_start) begin
                count <= `TCP_CNT_RELOAD;
            end else if (tick) begin
                count <= count + 16'h0001;
            end
        end
    end

    // ********************************************************
    // compare channels
    // ********************************************************
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cmp
            tcp_word_t target;
            logic hi_wr;
            logic lo_wr;
            assign hi_wr = wr && wb_adr_i == (gi == 0 ? `TCP_ADR_CMP1_HI
                                                       : `TCP_ADR_CMP2_HI);
            assign lo_wr = wr && wb_adr_i == (gi == 0 ? `TCP_ADR_CMP1_LO
                                                       : `TCP_ADR_CMP2_LO);
            // divide-by-2 hits at the value itself, others one later
            assign target = (clk_sel == `TCP_CLK_DIV2) ? active_cmp[gi]
                : active_cmp[gi] + `TCP_CMP_ADJ;
            assign match[gi] = count_new & ~inhibit[gi] & (count == target);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    compare_high_byte[gi] <= `TCP_CMP_HI_RST;
                    compare_low_byte[gi] <= `TCP_CMP_LO_RST;
                    inhibit[gi] <= 1'b0;
                end else if (hi_wr) begin
                    compare_high_byte[gi] <= wb_dat_i[7:0];
                    inhibit[gi] <= 1'b1;
                end else if (lo_wr) begin
                    compare_low_byte[gi] <= wb_dat_i[7:0];
                    inhibit[gi] <= 1'b0;
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    active_cmp[gi] <= {`TCP_CMP_HI_RST, `TCP_CMP_LO_RST};
                end else if (mode != TCP_PWM || pwm_end) begin
                    active_cmp[gi] <= {compare_high_byte[gi],
                                       compare_low_byte[gi]};
                end
            end
        end
    endgenerate

    // ********************************************************
    // flags and captures
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= 8'h00;
        end else begin
            // set wins over a clear in the same cycle
            flags <= (flags & ~((wr && wb_adr_i == `TCP_ADR_STATUS)
                                ? wb_dat_i[7:0] : 8'h00))
                | ({7'h00, (mode != TCP_PWM) & match[0]}
                   << `TCP_F_MATCH1)
                | ({7'h00, (mode != TCP_PWM) & match[1]}
                   << `TCP_F_MATCH2)
                | ({7'h00, pwm_end | ((mode != TCP_PWM) & cap1_edge)}
                   << `TCP_F_CAP1)
                | ({7'h00, cap2_edge} << `TCP_F_CAP2)
                | ({7'h00, tick & ~pwm_end & ~opm_start
                    & (count == `TCP_CNT_TOP)} << `TCP_F_OVF);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_capture_value <= 16'h0000;
            second_capture_value <= 16'h0000;
        end else begin
            if (mode != TCP_PWM && cap1_edge) begin
                first_capture_value <= count;
            end
            if (cap2_edge) begin
                second_capture_value <= count;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_irq_o <= 1'b0;
        end else begin
            timer_irq_o <= (timer_control_one[`TCP_B_CAP_IE]
                    & (flags[`TCP_F_CAP1] | flags[`TCP_F_CAP2]))
                | (timer_control_one[`TCP_B_MATCH_IE]
                    & (flags[`TCP_F_MATCH1] | flags[`TCP_F_MATCH2]))
                | (timer_control_one[`TCP_B_OVF_IE]
                    & flags[`TCP_F_OVF]);
        end
    end

    // ********************************************************
    // compare pins
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_compare_pin_o <= 1'b0;
            first_compare_pin_oe_n_o <= 1'b1;
        end else begin
            first_compare_pin_oe_n_o <=
                ~timer_control_two[`TCP_B_PIN1_EN];
            if (timer_control_two[`TCP_B_PIN1_EN]) begin
                unique case (mode)
                    TCP_NORMAL: begin
                        if (timer_control_one[`TCP_B_FORCE1] | match[0]) begin
                            first_compare_pin_o <=
                                timer_control_one[`TCP_B_LVL1];
                        end
                    end
                    TCP_ONE_PULSE: begin
                        if (opm_start) begin
                            first_compare_pin_o <=
                                timer_control_one[`TCP_B_LVL2];
                        end else if (match[0]) begin
                            first_compare_pin_o <=
                                timer_control_one[`TCP_B_LVL1];
                        end
                    end
                    TCP_PWM: begin
                        if (match[1]) begin
                            first_compare_pin_o <=
                                timer_control_one[`TCP_B_LVL2];
                        end else if (match[0]) begin
                            first_compare_pin_o <=
                                timer_control_one[`TCP_B_LVL1];
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            second_compare_pin_o <= 1'b0;
            second_compare_pin_oe_n_o <= 1'b1;
        end else begin
            second_compare_pin_oe_n_o <=
                ~timer_control_two[`TCP_B_PIN2_EN];
            if (timer_control_two[`TCP_B_PIN2_EN] && mode == TCP_NORMAL
                && (timer_control_one[`TCP_B_FORCE2] | match[1])) begin
                second_compare_pin_o <= timer_control_one[`TCP_B_LVL2];
            end
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_pwm_period_end;
        mode == TCP_PWM && match[1];
    endsequence

    a_hi_suspends: assert property (inhibit[0] |-> ##1
        !$rose(flags[`TCP_F_MATCH1]))
        else $error("compare matched while high byte pending");
    a_pin_left: assert property (
        !timer_control_two[`TCP_B_PIN1_EN] |=> $stable(first_compare_pin_o))
        else $error("disabled first pin changed level");
    a_fast_match: assert property (
        clk_sel == `TCP_CLK_DIV2 && count_new && !inhibit[0]
        && mode == TCP_NORMAL && count == active_cmp[0]
        |=> flags[`TCP_F_MATCH1])
        else $error("divide-by-2 match missed at compare value");
    a_force_copy: assert property (
        mode == TCP_NORMAL && timer_control_one[`TCP_B_FORCE1]
        && timer_control_two[`TCP_B_PIN1_EN]
        |=> first_compare_pin_o == $past(timer_control_one[`TCP_B_LVL1]))
        else $error("forced level not copied to first pin");
    a_pwm_reload: assert property (s_pwm_period_end |=>
        count == `TCP_CNT_RELOAD)
        else $error("period end did not reload counter");
    a_pwm_capflag: assert property (s_pwm_period_end |=>
        flags[`TCP_F_CAP1])
        else $error("period end did not set first capture flag");
    a_pwm_noflag: assert property (mode == TCP_PWM |=>
        !$rose(flags[`TCP_F_MATCH1]) && !$rose(flags[`TCP_F_MATCH2]))
        else $error("match flag set in modulation mode");
    a_pwm_only: assert property (
        timer_control_two[`TCP_B_PWM] |-> mode == TCP_PWM && !opm_start)
        else $error("modulation bit not dominant");
    a_pwm_level: assert property (
        s_pwm_period_end ##0 timer_control_two[`TCP_B_PIN1_EN]
        |=> first_compare_pin_o == $past(timer_control_one[`TCP_B_LVL2]))
        else $error("second level not applied at period end");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held two cycles");
endmodule : tcp_unit
`default_nettype wire

/* File: verification/tcp_pin_model.sv */
// model of the capture pins and external timer clock
`default_nettype none
module tcp_pin_model (
    input wire logic clk_i,
    output logic cap1_o,
    output logic cap2_o,
    output logic ext_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int div = 0;
    initial begin
        cap1_o = 1'b1;
        cap2_o = 1'b1;
        ext_o = 1'b0;
    end
    // slow free-running clock, six cycles a level
    always @(posedge clk_i) begin
        div <= (div == 5) ? 0 : div + 1;
        if (div == 5) begin
            ext_o <= ~ext_o;
        end
    end
    // low pulse: falling then rising edge
    task automatic pulse(input bit second);
        @(posedge clk_i);
        if (second) cap2_o <= 1'b0;
        else cap1_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        if (second) cap2_o <= 1'b1;
        else cap1_o <= 1'b1;
    endtask : pulse
endmodule : tcp_pin_model
`default_nettype wire

/* File: verification/timer_compare_pwm_unit_tb.sv */
// self-checking bench of the timer compare unit
`default_nettype none
`include "tcp_regs.svh"
module timer_compare_pwm_unit_tb import tcp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [5:0] adr; logic [7:0] wr;
        logic [31:0] exp;} tcp_row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] q;
    logic ack, pin1, oe1_n, pin2, oe2_n, irq, cap1, cap2, ext;
    int num_errors = 0;
    int num_checks = 0;
    int hi, lo;
    tcp_word_t b;
    tcp_row_s rows [9] = '{'{`TCP_ADR_CTRL1, 8'hA5, 32'hA5},
        '{`TCP_ADR_CTRL2, 8'h08, 32'h08}, '{`TCP_ADR_CMP1_HI, 8'h12, 32'h12},
        '{`TCP_ADR_CMP1_LO, 8'h34, 32'h34}, '{`TCP_ADR_CMP2_HI, 8'h56, 32'h56},
        '{`TCP_ADR_CMP2_LO, 8'h78, 32'h78}, '{6'h3C, 8'hFF, 32'h00},
        '{`TCP_ADR_CTRL1, 8'h00, 32'h00}, '{`TCP_ADR_CTRL2, 8'h00, 32'h00}};

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    tcp_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .first_capture_input_i(cap1),
        .second_capture_input_i(cap2), .ext_timer_clock_pin_i(ext),
        .first_compare_pin_o(pin1), .first_compare_pin_oe_n_o(oe1_n),
        .second_compare_pin_o(pin2), .second_compare_pin_oe_n_o(oe2_n),
        .timer_irq_o(irq));
    tcp_pin_model pins (.clk_i(clk_i), .cap1_o(cap1), .cap2_o(cap2),
        .ext_o(ext));

    //****************************************
    // shared tasks
    //****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00);
        chk(q, exp);
    endtask : rd
    task automatic setcmp(input logic [5:0] a, input tcp_word_t v);
        wb(1'b1, a, v[15:8]);
        wb(1'b1, a + 6'h04, v[7:0]);
    endtask : setcmp
    task automatic wait_pin(input logic v, output int n);
        n = 0;
        while (pin1 !== v && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, pin1}, {31'h0, v});
    endtask : wait_pin
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    //****************************************
    // tests
    //****************************************
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(1'b1, rows[i].adr, rows[i].wr);
            rd(rows[i].adr, rows[i].exp);
        end
        $display("test register rows done");
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`TCP_ADR_CTRL1, 32'h0);
        rd(`TCP_ADR_CTRL2, 32'h0);
        rd(`TCP_ADR_CMP1_HI, 32'h80);
        chk({30'h0, oe1_n, oe2_n}, 32'h3);
        $display("test reset done");
        wb(1'b1, `TCP_ADR_CTRL2, 8'h04);
        wb(1'b1, `TCP_ADR_CTRL1, 8'h41);
        wb(1'b0, `TCP_ADR_COUNT, 8'h00);
        b = q[15:0] + 16'h0060;
        wb(1'b1, `TCP_ADR_CMP1_LO, b[7:0]);
        wb(1'b1, `TCP_ADR_CMP1_HI, b[15:8]);
        wb(1'b1, `TCP_ADR_STATUS, 8'hF8);
        repeat (300) @(posedge clk_i);
        rd(`TCP_ADR_STATUS, 32'h0);
        wb(1'b0, `TCP_ADR_COUNT, 8'h00);
        setcmp(`TCP_ADR_CMP1_HI, q[15:0] + 16'h0040);
        repeat (200) @(posedge clk_i);
        rd(`TCP_ADR_STATUS, 32'h40);
        chk({29'h0, pin1, oe1_n, irq}, 32'h3);
        $display("test compare done");
        wb(1'b1, `TCP_ADR_STATUS, 8'hF8);
        wb(1'b1, `TCP_ADR_CTRL2, 8'hC4);
        wb(1'b1, `TCP_ADR_CTRL1, 8'h1D);
        repeat (4) @(posedge clk_i);
        chk({27'h0, pin1, oe1_n, pin2, oe2_n, irq}, 32'h14);
        rd(`TCP_ADR_STATUS, 32'h0);
        $display("test force done");
        wb(1'b0, `TCP_ADR_COUNT, 8'h00);
        b = q[15:0] + 16'h0100;
        setcmp(`TCP_ADR_CMP1_HI, b);
        setcmp(`TCP_ADR_CMP2_HI, b + 16'h0030);
        wb(1'b1, `TCP_ADR_CTRL1, 8'h89);
        wb(1'b1, `TCP_ADR_CTRL2, 8'hB4);
        wb(1'b1, `TCP_ADR_STATUS, 8'hF8);
        wait_pin(1'b0, hi);
        wait_pin(1'b1, hi);
        wait_pin(1'b0, hi);
        wait_pin(1'b1, lo);
        chk(hi, 96);
        chk(lo >= 2 * b + 6 && lo <= 2 * b + 12, 1);
        wb(1'b0, `TCP_ADR_STATUS, 8'h00);
        chk(q & 32'hD8, 32'h80);
        chk({31'h0, irq}, 32'h1);
        setcmp(`TCP_ADR_CMP1_HI, b + 16'h0010);
        wait_pin(1'b0, hi);
        wait_pin(1'b1, hi);
        wait_pin(1'b0, hi);
        chk(hi, 64);
        wb(1'b1, `TCP_ADR_STATUS, 8'hF8);
        pins.pulse(1'b0);
        pins.pulse(1'b1);
        repeat (10) @(posedge clk_i);
        wb(1'b0, `TCP_ADR_STATUS, 8'h00);
        chk(q & 32'h10, 32'h10);
        rd(`TCP_ADR_CAP1, 32'h0);
        $display("test modulation done");
        wb(1'b1, `TCP_ADR_CTRL1, 8'h06);
        setcmp(`TCP_ADR_CMP1_HI, 16'h0020);
        wb(1'b1, `TCP_ADR_CTRL2, 8'hA4);
        pins.pulse(1'b0);
        wait_pin(1'b1, hi);
        wait_pin(1'b0, hi);
        pins.pulse(1'b0);
        wait_pin(1'b1, lo);
        wait_pin(1'b0, hi);
        chk(hi >= 68 && hi <= 76, 1);
        $display("test one pulse done");
        wb(1'b1, `TCP_ADR_CTRL2, 8'h0C);
        wb(1'b0, `TCP_ADR_COUNT, 8'h00);
        b = q[15:0] + 16'h0003;
        setcmp(`TCP_ADR_CMP1_HI, b);
        wb(1'b1, `TCP_ADR_STATUS, 8'hF8);
        wb(1'b0, `TCP_ADR_STATUS, 8'h00);
        chk(q & 32'h40, 32'h0);
        do begin
            wb(1'b0, `TCP_ADR_STATUS, 8'h00);
        end while (q[`TCP_F_MATCH1] !== 1'b1);
        wb(1'b0, `TCP_ADR_COUNT, 8'h00);
        chk(q, {16'h0000, b + 16'h0001});
        $display("test external clock done");
        tally_and_finish();
    end

    initial begin
        repeat (40000) @(posedge clk_i);
        num_errors++;
        $display("watchdog expired at %0t", $time);
        tally_and_finish();
    end
endmodule : timer_compare_pwm_unit_tb
`default_nettype wire
